// *** design/logic_group_defs.vh ***
// Constants for the logic fabric: register offsets, field positions,
// reset values and bus response codes.
// Assumes it is included by bare name by the fabric top module.
`ifndef LOGIC_GROUP_DEFS_VH
`define LOGIC_GROUP_DEFS_VH

// Register byte offsets (12-bit address space)
`define CELL_CFG_BASE 12'h000
`define CELL_CFG_END 12'h120
`define CARRY_CFG_ADDR 12'h120
`define STATUS0_ADDR 12'h124
`define STATUS1_ADDR 12'h128
`define STATUS2_ADDR 12'h12C
`define CTRL_ADDR 12'h130

// Cell configuration word layout
`define CF_W 17
`define CF_LUT 0
`define CF_ARITH 4
`define CF_SUB 5
`define CF_INV_A 6
`define CF_INV_B 7
`define CF_IGN_A 8
`define CF_IGN_B 9
`define CF_CSEL 10
`define CF_BYPASS 12
`define CF_PRELOAD 13
`define CF_CLR_EN 14
`define CF_P2M 15

// Clock source codes
`define CSEL_PTERM 2'h0
`define CSEL_GCLK0 2'h1

// Multi-use private term modes
`define P2M_SUM 2'h0
`define P2M_PRESET 2'h1
`define P2M_OE 2'h2

// Carry entry modes per group
`define CARRY_CHAIN 2'h0
`define CARRY_ZERO 2'h1
`define CARRY_ONE 2'h2

// Reset values and the run bit position
`define CELL_CFG_RST 17'h00000
`define CARRY_CFG_RST 16'h0000
`define CTRL_RUN_BIT 0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** design/logic_fabric.v ***
// Logic fabric: eight logic groups of nine logic cells joined by a
// shared crossbar, with an AXI4-Lite slave for per-cell options.
// Assumes crossbar and product-term maps are static inputs, and that
// software configures the cells before setting the run bit.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "logic_group_defs.vh"

module logic_fabric #(
  parameter N_GROUPS = 8,
  parameter N_CELLS = 9,
  parameter N_XIN = 21,
  parameter N_PRIV = 5,
  parameter N_SHARED = 12,
  parameter N_EXT = 54
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] global_low_skew_clock,
  input wire [N_EXT-1:0] ext_in,
  input wire [N_GROUPS*N_XIN*(N_GROUPS*N_CELLS+N_EXT)-1:0] xbar_map,
  input wire [N_GROUPS*(N_CELLS*N_PRIV+N_SHARED)*2*N_XIN-1:0] and_map,
  input wire [N_GROUPS*N_CELLS*N_SHARED-1:0] share_sel_a,
  input wire [N_GROUPS*N_CELLS*N_SHARED-1:0] share_sel_b,
  input wire carry_chain_in,
  output wire carry_chain_out,
  output wire [N_GROUPS*N_CELLS-1:0] cell_out,
  output wire [N_GROUPS*N_CELLS-1:0] cell_oe
);

  localparam N_TOT = N_GROUPS * N_CELLS;
  localparam N_IN = N_TOT + N_EXT;
  localparam N_OUT = N_GROUPS * N_XIN;
  localparam N_LIT = 2 * N_XIN;
  localparam N_TERMS = N_CELLS * N_PRIV + N_SHARED;

  // AND of all connected crossbar inputs; unconnected reads high
  function xbar_and;
    input [N_IN-1:0] v;
    input [N_IN-1:0] m;
    begin
      xbar_and = &(v | ~m);
    end
  endfunction

  // Product term over the selected literals; an empty term reads low
  function pterm;
    input [N_LIT-1:0] lit;
    input [N_LIT-1:0] m;
    begin
      pterm = (|m) & (&(lit | ~m));
    end
  endfunction

  // Byte-lane merge of a write into an existing word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (s[b])
          merge[b*8 +: 8] = d[b*8 +: 8];
    end
  endfunction

  reg [`CF_W-1:0] cfg_q [0:N_TOT-1];
  reg [2*N_GROUPS-1:0] carry_cfg_q;
  reg run_q;
  reg [N_TOT-1:0] stat_s1_q;
  reg [N_TOT-1:0] stat_s2_q;
  reg aw_got_q;
  reg w_got_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rd_data;
  reg rd_ok;
  wire [N_TOT-1:0] feedback;
  wire [N_IN-1:0] xin;
  wire [N_OUT-1:0] xout;
  wire [N_TOT:0] carry;
  wire do_wr;
  wire wr_cell;
  wire wr_ok;
  wire [6:0] wr_idx;
  wire [6:0] rd_idx;
  wire [31:0] wr_word;
  wire [95:0] stat_pad;
  integer i;

  // Crossbar: every line is the AND of its routed inputs
  assign xin = {ext_in, feedback};
  genvar o;
  generate
    for (o = 0; o < N_OUT; o = o + 1)
    begin : g_xbar
      // Disabled feedback is high, so one enabled line sets the level
      assign xout[o] = xbar_and(xin, xbar_map[o*N_IN +: N_IN]);
    end
  endgenerate

  assign carry[0] = carry_chain_in;
  assign carry_chain_out = carry[N_TOT];

  genvar g;
  genvar t;
  genvar c;
  generate
    for (g = 0; g < N_GROUPS; g = g + 1)
    begin : g_grp
      wire [N_XIN-1:0] gin;
      wire [N_LIT-1:0] lit;
      wire [N_TERMS-1:0] pt;
      wire [N_SHARED-1:0] shared;
      wire [1:0] cmode;
      assign gin = xout[g*N_XIN +: N_XIN];
      assign lit = {~gin, gin};
      assign cmode = carry_cfg_q[2*g +: 2];
      // Private terms first, shared terms on top
      for (t = 0; t < N_TERMS; t = t + 1)
      begin : g_pt
        assign pt[t] = pterm(lit, and_map[(g*N_TERMS+t)*N_LIT +: N_LIT]);
      end
      assign shared = pt[N_CELLS*N_PRIV +: N_SHARED];
      for (c = 0; c < N_CELLS; c = c + 1)
      begin : g_cell
        localparam IDX = g * N_CELLS + c;
        wire [N_PRIV-1:0] pv;
        wire [`CF_W-1:0] cf;
        wire [1:0] p2m;
        wire [1:0] csel;
        wire clr_on;
        wire pre_on;
        wire oe_on;
        wire sum_a;
        wire sum_b;
        wire a_op;
        wire b_op;
        wire b_ar;
        wire cin;
        wire d;
        wire cclk;
        wire clr_a;
        wire pre_a;
        wire q_out;
        reg ff_q;
        assign pv = pt[c*N_PRIV +: N_PRIV];
        assign cf = cfg_q[IDX];
        assign p2m = cf[`CF_P2M +: 2];
        assign csel = cf[`CF_CSEL +: 2];
        // Term 1 may clear; term 2 may preset or gate the output
        assign clr_on = cf[`CF_CLR_EN] & pv[1];
        assign pre_on = (p2m == `P2M_PRESET) & pv[2];
        assign oe_on = (p2m == `P2M_OE) ? pv[2] : 1'b1;
        // Terms 3 and 4 join the A sum, term 1 when clear is off and term 2 in sum mode only; term 0 never does
        assign sum_a = pv[3] | pv[4] | (~cf[`CF_CLR_EN] & pv[1]) |
          ((p2m == `P2M_SUM) & pv[2]) |
          (|(shared & share_sel_a[IDX*N_SHARED +: N_SHARED]));
        assign sum_b =
          |(shared & share_sel_b[IDX*N_SHARED +: N_SHARED]);
        // Optional inversion, or forced low when ignored
        assign a_op = ~cf[`CF_IGN_A] & (sum_a ^ cf[`CF_INV_A]);
        assign b_op = ~cf[`CF_IGN_B] & (sum_b ^ cf[`CF_INV_B]);
        assign b_ar = b_op ^ cf[`CF_SUB];
        // Carry at group entry: chain or forced constant
        if (c == 0)
        begin : g_entry
          assign cin = (cmode == `CARRY_ZERO) ? 1'b0 :
            (cmode == `CARRY_ONE) ? 1'b1 : carry[IDX];
        end
        else
        begin : g_link
          assign cin = carry[IDX];
        end
        assign carry[IDX+1] = cf[`CF_ARITH] &
          ((a_op & b_ar) | (cin & (a_op ^ b_ar)));
        // Sum in arithmetic mode, table lookup in logic mode
        assign d = cf[`CF_ARITH] ? (a_op ^ b_ar ^ cin) :
          cf[`CF_LUT + {b_op, a_op}];
        // Clock source: own term or a global clock
        assign cclk = (csel == `CSEL_PTERM) ? pv[0] :
          (csel == `CSEL_GCLK0) ? global_low_skew_clock[0] :
          global_low_skew_clock[1];
        // Held in preload state until software sets run
        assign clr_a = clr_on | (~run_q & ~cf[`CF_PRELOAD]);
        assign pre_a = pre_on | (~run_q & cf[`CF_PRELOAD]);
        // Cell flip-flop; clear wins over preset
        always @(posedge cclk or posedge clr_a or posedge pre_a)
        begin
          if (clr_a)
            ff_q <= 1'b0;
          else if (pre_a)
            ff_q <= 1'b1;
          else
            ff_q <= d;
        end
        assign q_out = cf[`CF_BYPASS] ? d : ff_q;
        assign cell_out[IDX] = q_out;
        assign cell_oe[IDX] = oe_on & run_q;
        assign feedback[IDX] = cell_oe[IDX] ? q_out : 1'b1;
      end
    end
  endgenerate

  // Bus handshake outputs
  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready = ~w_got_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Write decode once address and data are both held
  assign do_wr = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_cell = awaddr_q < `CELL_CFG_END;
  assign wr_idx = awaddr_q[8:2];
  assign wr_ok = wr_cell | (awaddr_q[11:2] == `CARRY_CFG_ADDR >> 2) |
    (awaddr_q[11:2] == `CTRL_ADDR >> 2) |
    (awaddr_q[11:2] == `STATUS0_ADDR >> 2) |
    (awaddr_q[11:2] == `STATUS1_ADDR >> 2) |
    (awaddr_q[11:2] == `STATUS2_ADDR >> 2);
  assign wr_word = merge(wr_cell ? {{(32-`CF_W){1'b0}}, cfg_q[wr_idx]} :
    {{(32-2*N_GROUPS){1'b0}}, carry_cfg_q}, wdata_q, wstrb_q);

  // Write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Configuration registers; status words ignore writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (i = 0; i < N_TOT; i = i + 1)
        cfg_q[i] <= `CELL_CFG_RST;
      carry_cfg_q <= `CARRY_CFG_RST;
      run_q <= 1'b0;
    end
    else if (do_wr)
    begin
      if (wr_cell && (wr_idx < N_TOT))
        cfg_q[wr_idx] <= wr_word[`CF_W-1:0];
      if (awaddr_q[11:2] == `CARRY_CFG_ADDR >> 2)
        carry_cfg_q <= wr_word[2*N_GROUPS-1:0];
      if ((awaddr_q[11:2] == `CTRL_ADDR >> 2) && wstrb_q[0])
        run_q <= wdata_q[`CTRL_RUN_BIT];
    end
  end

  // Two-stage capture of the cell outputs for status reads
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_s1_q <= {N_TOT{1'b0}};
      stat_s2_q <= {N_TOT{1'b0}};
    end
    else
    begin
      stat_s1_q <= cell_out;
      stat_s2_q <= stat_s1_q;
    end
  end

  assign stat_pad = {{(96-N_TOT){1'b0}}, stat_s2_q};
  assign rd_idx = s_axi_araddr[8:2];

  // Read decode
  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr < `CELL_CFG_END)
      rd_data = {{(32-`CF_W){1'b0}}, cfg_q[rd_idx]};
    else
    begin
      case (s_axi_araddr[11:2])
        `CARRY_CFG_ADDR >> 2:
          rd_data = {{(32-2*N_GROUPS){1'b0}}, carry_cfg_q};
        `STATUS0_ADDR >> 2:
          rd_data = stat_pad[31:0];
        `STATUS1_ADDR >> 2:
          rd_data = stat_pad[63:32];
        `STATUS2_ADDR >> 2:
          rd_data = stat_pad[95:64];
        `CTRL_ADDR >> 2:
          rd_data = {31'h00000000, run_q};
        default:
          rd_ok = 1'b0;
      endcase
    end
  end

  // Read channel: one cycle from address to data
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

endmodule // logic_fabric

`default_nettype wire

// *** verification/logic_fabric_chk.sv ***
// Checker for the fabric: bus handshakes and the state after reset.
// Assumes it is bound to the fabric top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module logic_fabric_chk #(
  parameter N_GROUPS = 8,
  parameter N_CELLS = 9
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_GROUPS*N_CELLS-1:0] cell_oe
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Write answered two cycles after both halves are taken
  property p_b_after_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid;
  endproperty
  a_b_after_both: assert property (p_b_after_both)
    else $error("write response late");
  property p_b_release;
    $fell(s_axi_bvalid) |-> $past(s_axi_bready);
  endproperty
  a_b_release: assert property (p_b_release)
    else $error("write response dropped early");
  property p_w_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refused: assert property (p_w_refused)
    else $error("write taken while answer pending");
  // Reads answer one cycle after the address is taken
  property p_r_after_ar;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after_ar: assert property (p_r_after_ar)
    else $error("read data late");
  property p_r_release;
    $fell(s_axi_rvalid) |-> $past(s_axi_rready);
  endproperty
  a_r_release: assert property (p_r_release)
    else $error("read data dropped early");
  property p_ar_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refused: assert property (p_ar_refused)
    else $error("read taken while data pending");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] > 10'h04C
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  // Outputs disabled and no bus answer pending in the cycle reset is released
  property p_reset_quiet;
    $rose(aresetn) |-> cell_oe == '0 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_oe: cover property ($rose(cell_oe[0]));
endmodule // logic_fabric_chk
`default_nettype wire

// *** verification/fabric_partner.sv ***
// Far-side model: external crossbar lines and the two global clocks.
// Assumes the bench raises tick for one bus cycle per edge wanted.
`timescale 1ns/1ps
`default_nettype none
module fabric_partner (
  input wire logic aclk,
  input wire logic [5:0] ext_req,
  input wire logic [1:0] tick,
  output logic [53:0] ext_in,
  output logic [1:0] gclk
);
  // Unused lines sit low, as tied pins would
  assign ext_in = {48'h0, ext_req};
  // Global clocks idle low and rise mid-cycle only when asked
  initial gclk = 2'h0;
  always @(negedge aclk) gclk <= tick;
endmodule // fabric_partner
`default_nettype wire

// *** verification/epld_function_block_macrocell_bench.sv ***
// Bench: configures cell 0 of group 0 over the bus and checks it.
// Assumes the checker and partner files are compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module epld_function_block_macrocell_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, carry_chain_in = 1'b0;
  logic [5:0] ext_req = 6'h00;
  logic [1:0] tick = 2'h0;
  logic [21167:0] xbar_map = '0;
  logic [19151:0] and_map = '0;
  logic [863:0] share_sel_a = '0;
  logic [863:0] share_sel_b = '0;
  logic [3:0] luts [3] = '{4'h8, 4'hE, 4'h6};
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, gclk;
  wire [31:0] s_axi_rdata;
  wire [53:0] ext_in;
  wire carry_chain_out;
  wire [71:0] cell_out, cell_oe;
  int err_total = 0;
  int comparisons = 0;
  // Bus clock, 100 ns period
  always #50 aclk = ~aclk;
  logic_fabric dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .global_low_skew_clock(gclk), .ext_in, .xbar_map, .and_map,
    .share_sel_a, .share_sel_b, .carry_chain_in, .carry_chain_out,
    .cell_out, .cell_oe);
  fabric_partner partner (.aclk, .ext_req, .tick, .ext_in, .gclk);
  // Compare one value and count it
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        err_total++;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Bus write; ready and response taken at each rising edge
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic b;
    logic [1:0] r;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      while (b !== 1'b1)
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        b = s_axi_bvalid;
        r = s_axi_bresp;
      end
      // Release, then let an edge pass before the next request
      s_axi_bready <= 1'b0;
      chk({29'h0, b, r}, {29'h0, 1'b1, er});
      @(posedge aclk);
    end
  endtask
  // Bus read with the same sampling scheme
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic v;
    logic [31:0] d;
    logic [1:0] r;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      v = 1'b0;
      while (v !== 1'b1)
      begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        v = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      s_axi_rready <= 1'b0;
      chk({29'h0, v, r}, {29'h0, 1'b1, er});
      chk(d, e);
      @(posedge aclk);
    end
  endtask
  // Look at cell 0 output or enable once the fabric has settled
  task look(input logic oe, input logic e);
    begin
      @(negedge aclk);
      chk({31'h0, oe ? cell_oe[0] : cell_out[0]}, {31'h0, e});
      @(posedge aclk);
    end
  endtask
  // One rising edge on the chosen global clock
  task pulse(input logic [1:0] t);
    begin
      tick <= t;
      @(posedge aclk);
      tick <= 2'h0;
      @(posedge aclk);
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Tests take under a thousand cycles; allow thirty thousand
  initial
  begin
    #3000000;
    err_total++;
    summarize;
  end
  // Lines 0-3 carry external 0-3, line 1 also external 5
  initial
  begin
    for (int o = 0; o < 4; o++)
      xbar_map[o*127+72] = 1'b1;
    xbar_map[203] = 1'b1;
    and_map[126] = 1'b1;
    and_map[1891] = 1'b1;
    and_map[44] = 1'b1;
    and_map[87] = 1'b1;
    share_sel_b[0] = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h120, 32'h0, 2'h0);
    rd(12'h200, 32'h0, 2'h2);
    wr(12'h200, 32'h1, 2'h2);
    wr(12'h000, 32'h2000, 2'h0);
    look(1'b0, 1'b1);
    wr(12'h130, 32'h1, 2'h0);
    rd(12'h000, 32'h2000, 2'h0);
    $display("test reset done");
    foreach (luts[i])
    begin
      wr(12'h000, 32'h1000 | luts[i], 2'h0);
      for (int ab = 0; ab < 4; ab++)
      begin
        ext_req <= {4'h8, ab[1:0]};
        look(1'b0, luts[i][ab]);
      end
    end
    wr(12'h000, 32'h100C, 2'h0);
    ext_req <= 6'h02;
    look(1'b0, 1'b0);
    wr(12'h000, 32'h120C, 2'h0);
    ext_req <= 6'h22;
    look(1'b0, 1'b0);
    wr(12'h000, 32'h104A, 2'h0);
    ext_req <= 6'h20;
    look(1'b0, 1'b1);
    $display("test logic done");
    wr(12'h000, 32'h1010, 2'h0);
    carry_chain_in <= 1'b1;
    ext_req <= 6'h21;
    look(1'b0, 1'b0);
    wr(12'h120, 32'h1, 2'h0);
    look(1'b0, 1'b1);
    wr(12'h120, 32'h2, 2'h0);
    carry_chain_in <= 1'b0;
    look(1'b0, 1'b0);
    wr(12'h000, 32'h1030, 2'h0);
    look(1'b0, 1'b1);
    ext_req <= 6'h23;
    look(1'b0, 1'b0);
    // Top cell adds two inverted zeros, so the chain end carries out
    wr(12'h11C, 32'h00D0, 2'h0);
    chk({31'h0, carry_chain_out}, 32'h1);
    $display("test arith done");
    // Cell still holds its preload 1; data 0 waits for a clock edge
    wr(12'h000, 32'h040A, 2'h0);
    ext_req <= 6'h20;
    look(1'b0, 1'b1);
    pulse(2'h1);
    look(1'b0, 1'b0);
    ext_req <= 6'h21;
    pulse(2'h2);
    look(1'b0, 1'b0);
    pulse(2'h1);
    look(1'b0, 1'b1);
    $display("test flop done");
    // Clear alone, preset alone, then both
    wr(12'h000, 32'hC40A, 2'h0);
    ext_req <= 6'h24;
    look(1'b0, 1'b0);
    ext_req <= 6'h28;
    look(1'b0, 1'b1);
    look(1'b1, 1'b1);
    rd(12'h124, 32'h1, 2'h0);
    ext_req <= 6'h2C;
    look(1'b0, 1'b0);
    wr(12'h000, 32'h1040A, 2'h0);
    ext_req <= 6'h20;
    look(1'b1, 1'b0);
    ext_req <= 6'h28;
    look(1'b1, 1'b1);
    $display("test control done");
    summarize;
  end
endmodule // epld_function_block_macrocell_bench
bind logic_fabric logic_fabric_chk #(.N_GROUPS(N_GROUPS),
  .N_CELLS(N_CELLS)) chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cell_oe);
`default_nettype wire
